// File: phy_tx_pkg.sv
// Purpose: constants and carrier types for the transmit port
// Assumes: system clock at 10 MHz
// Notes:   see summary below
//
// Summary of operation
// - reduced-pin mode takes di-bits on data lines 1:0, ignores lines 3:2.
// - reduced-pin mode samples enable and data on the reference clock itself.
// - carrier sense rises within 40 ns (100M) or 400 ns (10M) of transmit start.
// - carrier sense falls within 160 ns (100M) or 900 ns (10M) after transmit end.
package phy_tx_pkg;

  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_MII  = 2'h0,
    MODE_RMII = 2'h1,
    MODE_FIVE = 2'h2
  } port_mode_t;

  // ****************************************
  // timing
  // ****************************************
  localparam int RMII_10M_HOLD_CYCLES = 10;
  localparam int MII_10M_DIV          = 10;
  localparam int MII_100M_DIV         = 1;
  localparam int CRS_ON_100_NS        = 40;
  localparam int CRS_ON_10_NS         = 400;
  localparam int CRS_OFF_100_NS       = 160;
  localparam int CRS_OFF_10_NS        = 900;
  localparam int SYS_PERIOD_NS        = 100;
  localparam int CRS_OFF_10_CYC       = (CRS_OFF_10_NS / SYS_PERIOD_NS < 1) ? 1 : CRS_OFF_10_NS / SYS_PERIOD_NS;
  localparam int SYNC_STAGES          = 2;
  localparam int FIFO_DEPTH           = 8;

  // ****************************************
  // carrier
  // ****************************************
  typedef struct packed {
    logic [4:0] data;
    logic       err;
    logic       last;
  } tx_word_t;

  localparam int WORD_W = 7;

endpackage

// File: phy_tx_port.sv
// Purpose: transmit side of the controller port, link logic on reference clock
// Assumes: reference clock from the controller side; system clock 10 MHz
// Notes:   words cross to the system domain through a gray-pointer fifo
`timescale 1ns/1ns

// ****************************************
// fifo
// ****************************************
module phy_tx_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 8
) (
  input  wire logic             wr_clk_i,
  input  wire logic             rd_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  output logic [WIDTH-1:0]      rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0]      wgray_reg, rgray_reg;
  logic [AW:0]      wg_s1_reg, wg_s2_reg, rg_s1_reg, rg_s2_reg;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  assign wr_ready_o = (wgray_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]});
  assign rd_valid_o = (rgray_reg != wg_s2_reg);
  assign rd_data_o  = mem[rptr_reg[AW-1:0]];

  always_comb begin
    wptr_next = wptr_reg + (AW+1)'(wr_valid_i && wr_ready_o);
    rptr_next = rptr_reg + (AW+1)'(rd_valid_o && rd_ready_i);
  end

  always_ff @(posedge wr_clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      mem[wptr_reg[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge wr_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_reg  <= '0;
      wgray_reg <= '0;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      wptr_reg  <= wptr_next;
      wgray_reg <= to_gray(wptr_next);
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  always_ff @(posedge rd_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rptr_reg  <= '0;
      rgray_reg <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      rptr_reg  <= rptr_next;
      rgray_reg <= to_gray(rptr_next);
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
    end
  end
endmodule

// ****************************************
// top
// ****************************************
module phy_tx_port (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   reference_clock_input,
  input  wire phy_tx_pkg::port_mode_t mode_i,
  input  wire logic                   speed_100_i,
  input  wire logic                   tx_en_i,
  input  wire logic [3:0]             txd_i,
  input  wire logic                   tx_er_i,
  output logic                        tx_clk_o,
  output logic                        crs_o,
  output logic [4:0]                  sym_data_o,
  output logic                        sym_err_o,
  output logic                        sym_valid_o,
  output logic                        sym_last_o,
  input  wire logic                   sym_ready_i,
  output logic                        overflow_o
);
  // ****************************************
  // link domain
  // ****************************************
  phy_tx_pkg::tx_word_t      lw_reg, lw_next;
  logic                      lvalid_reg, lvalid_next;
  logic                      en_d_reg, en_d_next;
  logic [3:0]                div_reg, div_next;
  logic                      tclk_reg, tclk_next;
  logic [3:0]                hold_reg, hold_next;
  logic                      half_reg, half_next;
  logic [1:0]                lo_reg, lo_next;
  logic                      crs_l_reg, crs_l_next;
  logic                      wr_ready;
  logic                      ovf_l_reg, ovf_l_next;
  phy_tx_pkg::port_mode_t    mode_s1_reg, mode_s2_reg;
  logic                      spd_s1_reg, spd_s2_reg;
  logic                      rmii, five, fast, tick;
  logic [3:0]                div_max;

  always_comb begin
    rmii    = (mode_s2_reg == phy_tx_pkg::MODE_RMII);
    five    = (mode_s2_reg == phy_tx_pkg::MODE_FIVE);
    fast    = spd_s2_reg;
    div_max = fast ? 4'(phy_tx_pkg::MII_100M_DIV - 1) : 4'(phy_tx_pkg::MII_10M_DIV - 1);
    div_next = (div_reg >= div_max) ? 4'h0 : div_reg + 4'h1;
    tclk_next = fast ? ~tclk_reg : ((div_reg >= div_max) ? ~tclk_reg : tclk_reg);
    // sample point: rising transmit clock, or every reference edge in rmii
    tick = rmii ? 1'b1 : (fast ? ~tclk_reg : ((div_reg >= div_max) && ~tclk_reg));
    hold_next = hold_reg;
    half_next = half_reg;
    lo_next   = lo_reg;
    lw_next   = lw_reg;
    lvalid_next = 1'b0;
    en_d_next = en_d_reg;
    crs_l_next = crs_l_reg;
    if (tick) begin
      en_d_next  = tx_en_i;
      crs_l_next = tx_en_i;
      if (rmii) begin
        hold_next = (!tx_en_i || hold_reg >= 4'(phy_tx_pkg::RMII_10M_HOLD_CYCLES - 1) || fast)
                    ? 4'h0 : hold_reg + 4'h1;
        if (!tx_en_i) begin
          half_next = 1'b0;
        end else if (hold_reg == 4'h0) begin
          half_next = ~half_reg;
          if (!half_reg) begin
            lo_next = txd_i[1:0];
          end else begin
            lw_next = '{data: {1'h0, txd_i[1:0], lo_reg}, err: tx_er_i, last: 1'b0};
            lvalid_next = 1'b1;
          end
        end
      end else if (tx_en_i) begin
        lw_next = five ? '{data: {tx_er_i, txd_i}, err: 1'b0, last: 1'b0}
                       : '{data: {1'b0, txd_i}, err: tx_er_i, last: 1'b0};
        lvalid_next = 1'b1;
      end
      if (en_d_reg && !tx_en_i) begin
        lw_next = '{data: 5'h00, err: 1'b0, last: 1'b1};
        lvalid_next = 1'b1;
      end
    end
    // sticky level, so no drop is lost between system samples
    ovf_l_next = ovf_l_reg | (lvalid_reg && !wr_ready);
  end

  always_ff @(posedge reference_clock_input or posedge rst_i) begin
    if (rst_i) begin
      lw_reg      <= '0;
      lvalid_reg  <= 1'b0;
      en_d_reg    <= 1'b0;
      div_reg     <= 4'h0;
      tclk_reg    <= 1'b0;
      hold_reg    <= 4'h0;
      half_reg    <= 1'b0;
      lo_reg      <= 2'h0;
      crs_l_reg   <= 1'b0;
      ovf_l_reg   <= 1'b0;
      mode_s1_reg <= phy_tx_pkg::MODE_MII;
      mode_s2_reg <= phy_tx_pkg::MODE_MII;
      spd_s1_reg  <= 1'b0;
      spd_s2_reg  <= 1'b0;
    end else begin
      lw_reg      <= lw_next;
      lvalid_reg  <= lvalid_next;
      en_d_reg    <= en_d_next;
      div_reg     <= div_next;
      tclk_reg    <= tclk_next;
      hold_reg    <= hold_next;
      half_reg    <= half_next;
      lo_reg      <= lo_next;
      crs_l_reg   <= crs_l_next;
      ovf_l_reg   <= ovf_l_next;
      mode_s1_reg <= mode_i;
      mode_s2_reg <= mode_s1_reg;
      spd_s1_reg  <= speed_100_i;
      spd_s2_reg  <= spd_s1_reg;
    end
  end

  assign tx_clk_o = tclk_reg;
  assign crs_o    = crs_l_reg;

  // ****************************************
  // crossing
  // ****************************************
  phy_tx_pkg::tx_word_t rd_word;
  logic                 rd_valid;

  phy_tx_fifo #(
    .WIDTH (phy_tx_pkg::WORD_W),
    .DEPTH (phy_tx_pkg::FIFO_DEPTH)
  ) phy_tx_fifo_i (
    .wr_clk_i   (reference_clock_input),
    .rd_clk_i   (ref_clk_i),
    .rst_i      (rst_i),
    .wr_data_i  (lw_reg),
    .wr_valid_i (lvalid_reg),
    .wr_ready_o (wr_ready),
    .rd_data_o  (rd_word),
    .rd_valid_o (rd_valid),
    .rd_ready_i (!sym_valid_o || sym_ready_i)
  );

  // ****************************************
  // system domain
  // ****************************************
  logic                 ovf_s1_reg, ovf_s2_reg;
  logic                 ovf_reg, ovf_next;
  phy_tx_pkg::tx_word_t out_reg, out_next;
  logic                 ov_reg, ov_next;

  always_comb begin
    ovf_next = ovf_reg | ovf_s2_reg;
    ov_next  = ov_reg;
    out_next = out_reg;
    // refill the output stage when empty or being taken
    if (rd_valid && (!ov_reg || sym_ready_i)) begin
      ov_next  = 1'b1;
      out_next = rd_word;
    end else if (ov_reg && sym_ready_i) begin
      ov_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_s1_reg <= 1'b0;
      ovf_s2_reg <= 1'b0;
      ovf_reg    <= 1'b0;
      out_reg    <= '0;
      ov_reg     <= 1'b0;
    end else begin
      ovf_s1_reg <= ovf_l_reg;
      ovf_s2_reg <= ovf_s1_reg;
      ovf_reg    <= ovf_next;
      out_reg    <= out_next;
      ov_reg     <= ov_next;
    end
  end

  assign sym_data_o  = out_reg.data;
  assign sym_err_o   = out_reg.err;
  assign sym_last_o  = out_reg.last;
  assign sym_valid_o = ov_reg;
  assign overflow_o  = ovf_reg;
endmodule

// File: phy_tx_port_chk.sv
// Purpose: assertions on the transmit port outputs
// Assumes: bound to phy_tx_port, both clock domains watched
// Notes:   carrier sense fall checked at each link sample point, its rise outside reduced-pin mode only
`timescale 1ns/1ns
// ****************************************
// checker
// ****************************************
module phy_tx_port_chk (
  input wire logic                   ref_clk_i,
  input wire logic                   rst_i,
  input wire logic                   reference_clock_input,
  input wire phy_tx_pkg::port_mode_t mode_i,
  input wire logic                   tx_en_i,
  input wire logic                   tx_clk_o,
  input wire logic                   crs_o,
  input wire logic [4:0]             sym_data_o,
  input wire logic                   sym_err_o,
  input wire logic                   sym_last_o,
  input wire logic                   sym_valid_o,
  input wire logic                   sym_ready_i,
  input wire logic                   overflow_o
);
  property p_crs_on;
    @(posedge reference_clock_input) disable iff (rst_i)
      mode_i != phy_tx_pkg::MODE_RMII && $rose(tx_clk_o) && $past(tx_en_i) |-> crs_o;
  endproperty
  a_crs_on: assert property (p_crs_on) else $error("carrier sense late");
  property p_crs_off;
    @(posedge reference_clock_input) disable iff (rst_i)
      (mode_i == phy_tx_pkg::MODE_RMII || $rose(tx_clk_o)) && !$past(tx_en_i) |-> !crs_o;
  endproperty
  a_crs_off: assert property (p_crs_off) else $error("carrier sense stuck");
  property p_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      sym_valid_o && !sym_ready_i |=> sym_valid_o && $stable({sym_data_o, sym_err_o, sym_last_o});
  endproperty
  a_hold: assert property (p_hold) else $error("word changed while waiting");
  property p_rmii_top;
    @(posedge ref_clk_i) disable iff (rst_i)
      mode_i == phy_tx_pkg::MODE_RMII && sym_valid_o && !sym_last_o |-> sym_data_o[4] == 1'b0;
  endproperty
  a_rmii_top: assert property (p_rmii_top) else $error("upper bit set in reduced mode");
  property p_five_err;
    @(posedge ref_clk_i) disable iff (rst_i)
      mode_i == phy_tx_pkg::MODE_FIVE && sym_valid_o |-> !sym_err_o;
  endproperty
  a_five_err: assert property (p_five_err) else $error("error flag set in five-bit mode");
  c_frame: cover property (@(posedge ref_clk_i) disable iff (rst_i) sym_valid_o && sym_ready_i && sym_last_o);
  c_ovf: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(overflow_o));
  c_crs: cover property (@(posedge reference_clock_input) disable iff (rst_i) $rose(crs_o));
endmodule
bind phy_tx_port phy_tx_port_chk phy_tx_port_chk_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .reference_clock_input(reference_clock_input), .mode_i(mode_i), .tx_en_i(tx_en_i), .tx_clk_o(tx_clk_o),
  .crs_o(crs_o), .sym_data_o(sym_data_o), .sym_err_o(sym_err_o), .sym_last_o(sym_last_o),
  .sym_valid_o(sym_valid_o), .sym_ready_i(sym_ready_i), .overflow_o(overflow_o));

// File: mac_tx_model.sv
// Purpose: controller side driving the transmit port
// Assumes: mode and speed static during a frame
// Notes:   idle and unused lines carry inverted values
`timescale 1ns/1ns
// ****************************************
// model
// ****************************************
module mac_tx_model (
  input  wire logic                   link_clk_i,
  input  wire logic                   tx_clk_i,
  input  wire phy_tx_pkg::port_mode_t mode_i,
  input  wire logic                   speed_100_i,
  output logic                        tx_en_o,
  output logic [3:0]                  txd_o,
  output logic                        tx_er_o
);
  initial begin
    tx_en_o = 1'b0;
    txd_o = 4'hA;
    tx_er_o = 1'b0;
  end
  task automatic step(input logic [3:0] d, input logic e, input logic en);
    if (mode_i == phy_tx_pkg::MODE_RMII) begin
      repeat (speed_100_i ? 1 : 10) @(posedge link_clk_i);
    end else begin
      @(posedge tx_clk_i);
    end
    #1;
    tx_en_o = en;
    txd_o = d;
    tx_er_o = e;
  endtask
  task automatic send(input int n, input logic [4:0] b, input logic er);
    logic [4:0] s;
    for (int i = 0; i < n; i++) begin
      s = b + 5'(i);
      if (mode_i == phy_tx_pkg::MODE_RMII) begin
        step({~s[1:0], s[1:0]}, 1'b0, 1'b1);
        step({~s[3:2], s[3:2]}, 1'b0, 1'b1);
      end else begin
        step(s[3:0], (mode_i == phy_tx_pkg::MODE_FIVE) ? s[4] : er, 1'b1);
      end
    end
    step(~txd_o, 1'b0, 1'b0);
  endtask
endmodule

// File: phy_tx_port_bench.sv
// Purpose: self-checking bench for the transmit port
// Assumes: link clock 30 ns, system clock 100 ns
// Notes:   words collected at each accepted handshake
`timescale 1ns/1ns
// ****************************************
// bench
// ****************************************
module phy_tx_port_bench;
  logic                   ref_clk_i = 1'b0;
  logic                   lclk = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   speed = 1'b1;
  logic                   sym_ready = 1'b1;
  logic                   crs_seen = 1'b0;
  phy_tx_pkg::port_mode_t mode = phy_tx_pkg::MODE_MII;
  logic                   tx_en, tx_er, tx_clk, crs, sym_err, sym_valid, sym_last, overflow;
  logic [3:0]             txd;
  logic [4:0]             sym_data;
  phy_tx_pkg::tx_word_t   got[$];
  int                     bad_count = 0;
  int                     cmp_count = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  always #15 lclk = ~lclk;
  phy_tx_port phy_tx_port_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reference_clock_input(lclk), .mode_i(mode),
    .speed_100_i(speed), .tx_en_i(tx_en), .txd_i(txd), .tx_er_i(tx_er), .tx_clk_o(tx_clk), .crs_o(crs),
    .sym_data_o(sym_data), .sym_err_o(sym_err), .sym_valid_o(sym_valid), .sym_last_o(sym_last),
    .sym_ready_i(sym_ready), .overflow_o(overflow));
  mac_tx_model mac_tx_model_i (.link_clk_i(lclk), .tx_clk_i(tx_clk), .mode_i(mode), .speed_100_i(speed),
    .tx_en_o(tx_en), .txd_o(txd), .tx_er_o(tx_er));
  always @(posedge ref_clk_i) begin
    if (sym_valid === 1'b1 && sym_ready === 1'b1) got.push_back({sym_data, sym_err, sym_last});
    if (crs === 1'b1) crs_seen = 1'b1;
  end
  task chk(input logic [7:0] a, input logic [7:0] e);
    cmp_count++;
    if (a !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task complete_run;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic frame(input phy_tx_pkg::port_mode_t m, input logic sp, input int n, input logic [4:0] b,
                       input logic er);
    int k;
    logic [4:0] s;
    @(posedge ref_clk_i);
    #1;
    mode = m;
    speed = sp;
    repeat (3) @(posedge ref_clk_i);
    got.delete();
    crs_seen = 1'b0;
    mac_tx_model_i.send(n, b, er);
    k = 0;
    while (k < 200 && got.size() <= n) begin
      @(posedge ref_clk_i);
      k++;
    end
    chk(8'(got.size()), 8'(n + 1));
    for (int i = 0; i < n && i < got.size(); i++) begin
      s = b + 5'(i);
      chk({3'h0, got[i].data}, {3'h0, (m == phy_tx_pkg::MODE_FIVE) ? s : {1'b0, s[3:0]}});
      chk({7'h0, got[i].last}, 8'h00);
      if (m == phy_tx_pkg::MODE_MII) chk({7'h0, got[i].err}, {7'h0, er});
    end
    if (got.size() > n) chk({7'h0, got[n].last}, 8'h01);
    if (m != phy_tx_pkg::MODE_RMII) chk({7'h0, crs_seen}, 8'h01);
    repeat (20) @(posedge ref_clk_i);
    chk({7'h0, crs}, 8'h00);
  endtask
  task automatic t_mii100;
    frame(phy_tx_pkg::MODE_MII, 1'b1, 6, 5'h0A, 1'b0);
  endtask
  task automatic t_mii10;
    frame(phy_tx_pkg::MODE_MII, 1'b0, 4, 5'h0E, 1'b1);
  endtask
  task automatic t_rmii10;
    frame(phy_tx_pkg::MODE_RMII, 1'b0, 5, 5'h06, 1'b0);
  endtask
  task automatic t_rmii100;
    frame(phy_tx_pkg::MODE_RMII, 1'b1, 6, 5'h0B, 1'b0);
  endtask
  task automatic t_five;
    frame(phy_tx_pkg::MODE_FIVE, 1'b1, 6, 5'h1C, 1'b0);
  endtask
  task automatic t_overflow;
    @(posedge ref_clk_i);
    #1;
    mode = phy_tx_pkg::MODE_MII;
    speed = 1'b1;
    sym_ready = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    got.delete();
    mac_tx_model_i.send(12, 5'h03, 1'b0);
    repeat (10) @(posedge ref_clk_i);
    chk({7'h0, overflow}, 8'h01);
    chk({3'h0, sym_data}, 8'h03);
    #1;
    sym_ready = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    chk({7'h0, sym_valid}, 8'h00);
    chk({7'h0, got.size() > 7}, 8'h01);
    #1;
    rst_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk({7'h0, overflow}, 8'h00);
    chk({7'h0, sym_valid}, 8'h00);
  endtask
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    t_mii100();
    t_mii10();
    t_rmii10();
    t_rmii100();
    t_five();
    t_overflow();
    complete_run();
  end
endmodule
